// ==== rtl/pftr_regs.svh ====
// Codes and constants of the program flow trace status block
`ifndef PFTR_REGS_SVH
`define PFTR_REGS_SVH

// ==========================================================
// Fetch type status codes
`define PFTR_VF_NONE     3'h0
`define PFTR_VF_SEQ      3'h1
`define PFTR_VF_NTAKEN   3'h2
`define PFTR_VF_SYNC     3'h3
`define PFTR_VF_EXC      3'h4
`define PFTR_VF_INDIR    3'h5
`define PFTR_VF_DIRECT   3'h6
`define PFTR_VF_NTAKEN_F 3'h7
`define PFTR_QFLUSH_MAX  3'h5

// ==========================================================
// History flush status codes
`define PFTR_VFLS_DEBUG  2'h3

// ==========================================================
// Fetch show select codes and reset value
`define PFTR_FSS_ALL     2'h0
`define PFTR_FSS_COF     2'h1
`define PFTR_FSS_INDIR   2'h2
`define PFTR_FSS_SYNC    2'h3
`define PFTR_FSS_RST     2'h0

// ==========================================================
// Cycle type codes
`define PFTR_CT_NORMAL   4'h0
`define PFTR_CT_MARK     4'h1
`define PFTR_CT_EMUL     4'h2
`define PFTR_CT_PORT     4'h3
`define PFTR_CT_IBUS     4'h4
`define PFTR_CT_LBUS     4'h5
`define PFTR_CT_CNOCS    4'h6
`define PFTR_CT_IREG     4'h7
`define PFTR_CT_CS_BASE  4'h8

// ==========================================================
// Buffer shape
`define PFTR_FIFO_DEPTH  16
`define PFTR_ADDR_W      32

`endif

// ==== rtl/pftr_pkg.sv ====
// Types of the program flow trace status block
package pftr_pkg;

	// Fetch type reported by the core each clock
	typedef enum logic [2:0] {
		FK_NONE, FK_SEQ, FK_NTAKEN, FK_EXC, FK_INDIR, FK_DIRECT
	} pftr_kind_t;

	// Where a bus cycle goes
	typedef enum logic [2:0] {
		TG_EXT, TG_PORT, TG_EMUL, TG_IBUS, TG_LBUS, TG_IREG, TG_CNOCS,
		TG_CCS
	} pftr_target_t;

	// What the next status slot carries
	typedef enum logic [1:0] {
		ST_TYPE, ST_FLUSH, ST_DEBUG
	} pftr_state_t;

endpackage

// ==== rtl/pftr_top.sv ====
// Program flow trace status: status codes, show cycle filter, cycle queue
`timescale 1ns/1ps
`include "pftr_regs.svh"

// ==========================================================
// Show cycle queue
// Operation
// - Show select 00 every fetch, 01 all change-of-flow, 10 indirect only.
// - Select 11 shows only forced fetches with sync clear, indirect fetches with sync set.
// - New show select applies from the second instruction after the write.
// - Trace sync has no pin; debug port commands set and clear it.
// - Each sync change stalls fetch, tags next fetch and forces it visible.
// - Codes 000, 001, 010 are followed by more fetch type information.
// - Code 011 reports a sync change and tags the following fetch.
// - Code 100 reports an exception; its target fetch is tagged.
// - Codes 101, 110, 111 for indirect, direct taken and not taken branch.
// - Queue flush counts go out only in clocks with no fetch type.
// - A flush clock may carry 111 instead; flush counts never exceed five.
// - History flush status gives 0, 1 or 2 flushed instructions per clock.
// - History flush code 11 marks debug mode; trace capture ignores it.
// - In debug mode fetch type reads 000 and history flush reads 11.
// - A sync change during debug is the first report after debug ends.
// - Without a sync change the first report after debug is 101.
// - The first fetch after debug is tagged and made visible.
// - Cycle type 0000 normal, 0011 port replacement, 0111 internal register.
// - Code 0001 marks a reservation for data, indirect target for fetches.
// - Codes 0010 emulation, 0100 I-bus, 0101 L-bus, 0110 uncontrolled hit.
// - Codes 1000 to 1101 mark cache hits under the six chip selects.
// - Tagged fetch show cycles to internal or cache memory drive write/read low.
// - Every tagged cycle drives the address type bit high.
module pftr_fifo #(
	parameter int W = 38,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          srst_i,
	// Filling side
	input  wire logic          in_valid_i,
	output logic               in_ready_o,
	input  wire logic [W-1:0]  in_data_i,
	// Draining side
	output logic               out_valid_o,
	input  wire logic          out_ready_i,
	output logic [W-1:0]       out_data_o,
	// Fill level
	output logic [$clog2(D):0] level_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	// Handshakes; full and empty come from the level
	assign in_ready_o  = (cnt_q != D[AW:0]);
	assign out_valid_o = (cnt_q != '0);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem_q[rd_q];
	assign level_o     = cnt_q;

	// Storage has no reset; only pointers and count need a defined value
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	// Pointers wrap since depth is a power of two
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= push ? wr_q + 1'b1 : wr_q;
			rd_q  <= pop ? rd_q + 1'b1 : rd_q;
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

// ==========================================================
// Trace status top
module pftr_top
	import pftr_pkg::*;
#(
	parameter int DEPTH  = `PFTR_FIFO_DEPTH,
	parameter int ADDR_W = `PFTR_ADDR_W
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	// Core fetch status, one report per clock
	input  wire pftr_kind_t        fetch_kind_i,
	input  wire logic [2:0]        queue_flush_cnt_i,
	input  wire logic [1:0]        hist_flush_cnt_i,
	input  wire logic              debug_mode_i,
	output logic                   fetch_hold_o,
	// Show select move and instruction boundary
	input  wire logic              fss_wr_i,
	input  wire logic [1:0]        fss_data_i,
	input  wire logic              instr_done_i,
	output logic [1:0]             fetch_show_select_o,
	// Trace sync commands from the debug port logic
	input  wire logic              sync_set_i,
	input  wire logic              sync_clr_i,
	output logic                   trace_sync_o,
	// Bus cycle requests from the core
	input  wire logic              cyc_valid_i,
	output logic                   cyc_ready_o,
	input  wire logic              cyc_instr_i,
	input  wire pftr_target_t      cyc_target_i,
	input  wire logic [2:0]        cyc_cs_i,
	input  wire logic              cyc_resv_i,
	input  wire logic              cyc_write_i,
	input  wire logic [ADDR_W-1:0] cyc_addr_i,
	// Status pins
	output logic [2:0]             fetch_type_status_o,
	output logic [1:0]             history_flush_status_o,
	// External bus cycle, held until the bus takes it
	input  wire logic              bus_ack_i,
	output logic                   bus_valid_o,
	output logic [3:0]             cycle_type_code_o,
	output logic                   address_type_bit_o,
	output logic                   write_read_o,
	output logic [ADDR_W-1:0]      bus_addr_o
);
	localparam int RW = ADDR_W + 6;
	localparam int LW = $clog2(DEPTH) + 1;

	pftr_state_t    st_q, st_d;
	logic [2:0]     vf_q, vf_d;
	logic [1:0]     vfls_q, vfls_d;
	logic           sync_q, sync_chg, sync_nx;
	logic           sync_rep_q, rep_sync;
	logic           tag_q, force_q, cof_q;
	logic           tag_set, cof_set;
	logic [1:0]     fss_q, fss_new_q, fss_use;
	logic           fss_pend_q, fss_skip_q;
	logic           hold_q, ready_q;
	logic           accept, is_ext, show, push;
	logic [3:0]     ct;
	logic           wr_bit;
	logic [RW-1:0]  f_in, f_out;
	logic           f_in_rdy, f_out_vld, f_pop;
	logic [LW-1:0]  f_lvl;
	logic           bvalid_q;
	logic [RW-1:0]  bus_q;

	// ======================================================
	// Trace sync flag, driven only by debug port commands
	assign sync_nx  = sync_set_i ? 1'b1 : (sync_clr_i ? 1'b0 : sync_q);
	assign sync_chg = (sync_nx != sync_q);

	// Show select: old value covers the instruction after the move
	assign fss_use = (fss_pend_q & ~fss_skip_q) ? fss_new_q : fss_q;

	// ======================================================
	// Status report for this clock
	always_comb begin
		st_d     = st_q;
		vf_d     = `PFTR_VF_NONE;
		vfls_d   = hist_flush_cnt_i;
		rep_sync = 1'b0;
		tag_set  = 1'b0;
		cof_set  = 1'b0;
		if (debug_mode_i) begin
			vfls_d = `PFTR_VFLS_DEBUG;
			st_d   = ST_DEBUG;
		end else begin
			case (st_q)
				ST_DEBUG: begin
					tag_set = 1'b1;
					if (sync_rep_q) begin
						vf_d     = `PFTR_VF_SYNC;
						rep_sync = 1'b1;
						st_d     = ST_TYPE;
					end else begin
						vf_d = `PFTR_VF_INDIR;
						st_d = ST_FLUSH;
					end
				end
				ST_FLUSH: begin
					// Only a not-taken branch may take a flush slot
					if (fetch_kind_i == FK_NTAKEN) begin
						vf_d = `PFTR_VF_NTAKEN_F;
					end else begin
						vf_d = (queue_flush_cnt_i > `PFTR_QFLUSH_MAX) ?
							`PFTR_QFLUSH_MAX : queue_flush_cnt_i;
						st_d = ST_TYPE;
					end
				end
				ST_TYPE: begin
					if (sync_rep_q) begin
						// Fetch is held this clock, so no type is lost
						vf_d     = `PFTR_VF_SYNC;
						rep_sync = 1'b1;
						tag_set  = 1'b1;
					end else begin
						case (fetch_kind_i)
							FK_SEQ:    vf_d = `PFTR_VF_SEQ;
							FK_NTAKEN: vf_d = `PFTR_VF_NTAKEN;
							FK_EXC: begin
								vf_d    = `PFTR_VF_EXC;
								tag_set = 1'b1;
								st_d    = ST_FLUSH;
							end
							FK_INDIR: begin
								vf_d    = `PFTR_VF_INDIR;
								tag_set = 1'b1;
								st_d    = ST_FLUSH;
							end
							FK_DIRECT: begin
								vf_d    = `PFTR_VF_DIRECT;
								cof_set = 1'b1;
								st_d    = ST_FLUSH;
							end
							default:   vf_d = `PFTR_VF_NONE;
						endcase
					end
				end
				default: st_d = ST_TYPE;
			endcase
		end
	end

	// ======================================================
	// Bus cycle classification and show filter
	assign accept   = cyc_valid_i & ready_q;
	assign is_ext   = (cyc_target_i == TG_EXT);
	// Forced tags (sync change, debug exit) show under any select
	assign show = force_q | (fss_use == `PFTR_FSS_ALL)
		| ((fss_use == `PFTR_FSS_COF) & (tag_q | cof_q))
		| ((fss_use == `PFTR_FSS_INDIR) & tag_q)
		| ((fss_use == `PFTR_FSS_SYNC) & tag_q & sync_q);
	// Real external cycles and data always reach the bus
	assign push = accept & (~cyc_instr_i | is_ext | show);

	// Cycle type from target, tag and reservation
	assign ct =
		(cyc_target_i == TG_EXT) ?
			(((cyc_instr_i & tag_q) | (~cyc_instr_i & cyc_resv_i)) ?
			`PFTR_CT_MARK : `PFTR_CT_NORMAL) :
		(cyc_target_i == TG_PORT)  ? `PFTR_CT_PORT :
		(cyc_target_i == TG_IREG)  ? `PFTR_CT_IREG :
		(cyc_target_i == TG_EMUL)  ? `PFTR_CT_EMUL :
		(cyc_target_i == TG_IBUS)  ? `PFTR_CT_IBUS :
		(cyc_target_i == TG_LBUS)  ? `PFTR_CT_LBUS :
		(cyc_target_i == TG_CNOCS) ? `PFTR_CT_CNOCS :
		(`PFTR_CT_CS_BASE + {1'b0, cyc_cs_i});
	// Tagged internal or cache fetch drives write/read low
	assign wr_bit = cyc_instr_i ? ~(tag_q & ~is_ext
		& (cyc_target_i != TG_PORT)) : cyc_write_i;
	// Fetches carry the address type bit high
	assign f_in  = {ct, cyc_instr_i, wr_bit, cyc_addr_i};
	assign f_pop = ~bvalid_q | bus_ack_i;

	// Cycles wait here until the bus arbitration is won
	pftr_fifo #(
		.W (RW),
		.D (DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.srst_i      (srst_i),
		.in_valid_i  (push),
		.in_ready_o  (f_in_rdy),
		.in_data_i   (f_in),
		.out_valid_o (f_out_vld),
		.out_ready_i (f_pop),
		.out_data_o  (f_out),
		.level_o     (f_lvl)
	);

	// ======================================================
	// Status pins and tracking flags
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q       <= ST_TYPE;
			vf_q       <= `PFTR_VF_NONE;
			vfls_q     <= '0;
			sync_q     <= 1'b0;
			sync_rep_q <= 1'b0;
		end else begin
			st_q       <= st_d;
			vf_q       <= vf_d;
			vfls_q     <= vfls_d;
			sync_q     <= sync_nx;
			// A new change wins over the report that clears it
			sync_rep_q <= sync_chg | (sync_rep_q & ~rep_sync);
		end
	end

	// Tags live until the next fetch cycle consumes them
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tag_q   <= 1'b0;
			force_q <= 1'b0;
			cof_q   <= 1'b0;
		end else begin
			tag_q   <= tag_set | (tag_q & ~(accept & cyc_instr_i));
			force_q <= (tag_set & (st_q == ST_DEBUG | rep_sync))
				| (force_q & ~(accept & cyc_instr_i));
			cof_q   <= cof_set | (cof_q & ~(accept & cyc_instr_i));
		end
	end

	// Show select takes effect one instruction late
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fss_q      <= `PFTR_FSS_RST;
			fss_new_q  <= `PFTR_FSS_RST;
			fss_pend_q <= 1'b0;
			fss_skip_q <= 1'b0;
		end else if (fss_wr_i) begin
			fss_new_q  <= fss_data_i;
			fss_pend_q <= 1'b1;
			fss_skip_q <= 1'b1;
		end else if (fss_pend_q & instr_done_i) begin
			fss_skip_q <= 1'b0;
			fss_pend_q <= fss_skip_q;
			fss_q      <= fss_skip_q ? fss_q : fss_new_q;
		end
	end

	// Hold and ready are registered; two free slots cover the lag
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hold_q  <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			hold_q  <= sync_chg | (sync_rep_q & ~rep_sync);
			ready_q <= f_in_rdy
				& (f_lvl < LW'(DEPTH - 2)) & ~debug_mode_i;
		end
	end

	// Output stage for the external bus
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			bvalid_q <= 1'b0;
			bus_q    <= '0;
		end else if (f_pop) begin
			bvalid_q <= f_out_vld;
			bus_q    <= f_out_vld ? f_out : bus_q;
		end
	end

	assign fetch_type_status_o    = vf_q;
	assign history_flush_status_o = vfls_q;
	assign trace_sync_o           = sync_q;
	assign fetch_show_select_o    = fss_q;
	assign fetch_hold_o           = hold_q;
	assign cyc_ready_o            = ready_q;
	assign bus_valid_o            = bvalid_q;
	assign cycle_type_code_o      = bus_q[RW-1 -: 4];
	assign address_type_bit_o     = bus_q[ADDR_W+1];
	assign write_read_o           = bus_q[ADDR_W];
	assign bus_addr_o             = bus_q[ADDR_W-1:0];

	// ======================================================
	// Checks
	sequence s_sync_change;
		!debug_mode_i && sync_chg && st_q == ST_TYPE;
	endsequence
	sequence s_sync_report;
		##[1:2] vf_q == `PFTR_VF_SYNC;
	endsequence

	a_sync_reported: assert property (@(posedge clk_i) disable iff (srst_i)
		s_sync_change ##1 !debug_mode_i |-> s_sync_report)
		else $error("sync change not reported as 011");
	a_debug_pins: assert property (@(posedge clk_i) disable iff (srst_i)
		debug_mode_i |=> vf_q == `PFTR_VF_NONE && vfls_q == `PFTR_VFLS_DEBUG)
		else $error("debug mode pins wrong");
	a_debug_exit: assert property (@(posedge clk_i) disable iff (srst_i)
		st_q == ST_DEBUG && !debug_mode_i && !sync_rep_q
		|=> vf_q == `PFTR_VF_INDIR)
		else $error("first report after debug not 101");
	a_exit_sync: assert property (@(posedge clk_i) disable iff (srst_i)
		st_q == ST_DEBUG && !debug_mode_i && sync_rep_q
		|=> vf_q == `PFTR_VF_SYNC)
		else $error("sync change in debug not reported");
	a_flush_limit: assert property (@(posedge clk_i) disable iff (srst_i)
		$past(st_q) == ST_FLUSH && $past(!debug_mode_i)
		|-> vf_q <= `PFTR_QFLUSH_MAX || vf_q == `PFTR_VF_NTAKEN_F)
		else $error("flush slot out of range");
	a_taken_flush: assert property (@(posedge clk_i) disable iff (srst_i)
		st_q == ST_TYPE && !debug_mode_i && !sync_rep_q
		&& fetch_kind_i == FK_DIRECT |=> vf_q == `PFTR_VF_DIRECT ##0
		st_q == ST_FLUSH)
		else $error("direct branch not followed by flush slot");
	a_hist_cnt: assert property (@(posedge clk_i) disable iff (srst_i)
		!debug_mode_i |=> vfls_q == $past(hist_flush_cnt_i))
		else $error("history flush count not passed");
	a_fss_delay: assert property (@(posedge clk_i) disable iff (srst_i)
		fss_wr_i ##1 (!fss_wr_i && instr_done_i) |=> fss_q == $past(fss_q, 2))
		else $error("show select applied too early");
	a_hold_sync: assert property (@(posedge clk_i) disable iff (srst_i)
		sync_chg |=> fetch_hold_o)
		else $error("sync change did not hold fetch");
	a_no_show: assert property (@(posedge clk_i) disable iff (srst_i)
		accept && cyc_instr_i && !is_ext && !force_q && !sync_q
		&& fss_use == `PFTR_FSS_SYNC |-> !push)
		else $error("fetch shown with select 11 and sync clear");
endmodule

// ==== tb/pftr_trace_model.sv ====
// Trace capture and bus acceptor at the far side of the status pins
`timescale 1ns/1ps
module pftr_trace_model #(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	// Pacing set by the bench
	input  wire logic              stall_i,
	input  wire logic              slow_i,
	// Status pins and bus cycle
	input  wire logic [1:0]        vfls_i,
	input  wire logic              bus_valid_i,
	input  wire logic [3:0]        ct_i,
	input  wire logic              at_i,
	input  wire logic              wr_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	// Acknowledge and captured cycle
	output logic                   bus_ack_o,
	output logic [15:0]            cnt_o,
	output logic [15:0]            hist_o,
	output logic [3:0]             ct_o,
	output logic                   at_o,
	output logic                   wr_o,
	output logic [ADDR_W-1:0]      addr_o
);
	logic tog_q;

	// A slow bus takes a cycle only every other clock
	assign bus_ack_o = bus_valid_i & ~stall_i & (~slow_i | tog_q);

	// Capture every cycle taken and total the history flushes
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tog_q <= 1'b0;
			cnt_o <= 16'h0;
			hist_o <= 16'h0;
		end else begin
			tog_q <= ~tog_q;
			// Debug indication carries no flush count
			if (vfls_i != 2'h3) begin
				hist_o <= hist_o + {14'h0, vfls_i};
			end
			if (bus_ack_o) begin
				cnt_o <= cnt_o + 16'h1;
				ct_o <= ct_i;
				at_o <= at_i;
				wr_o <= wr_i;
				addr_o <= addr_i;
			end
		end
	end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench of the program flow trace status block
`timescale 1ns/1ps
module tb
	import pftr_pkg::*;
;
	logic clk_i, srst_i, debug_mode_i, fss_wr_i, instr_done_i;
	logic sync_set_i, sync_clr_i, cyc_valid_i, cyc_instr_i;
	logic cyc_resv_i, cyc_write_i, bus_ack_i, stall, slow;
	pftr_kind_t fetch_kind_i;
	pftr_target_t cyc_target_i;
	logic [2:0] queue_flush_cnt_i, cyc_cs_i, fetch_type_status_o;
	logic [1:0] hist_flush_cnt_i, fss_data_i, fetch_show_select_o;
	logic [1:0] history_flush_status_o;
	logic [31:0] cyc_addr_i, bus_addr_o, m_addr;
	logic fetch_hold_o, trace_sync_o, cyc_ready_o, bus_valid_o;
	logic address_type_bit_o, write_read_o, m_at, m_wr;
	logic [3:0] cycle_type_code_o, m_ct;
	logic [15:0] m_cnt, m_hist;
	logic [3:0] ect [8] = '{4'h0, 4'h3, 4'h2, 4'h4, 4'h5, 4'h7, 4'h6, 4'h8};
	int n_errors = 0;
	int n_compared = 0;

	pftr_top i_pftr_top (.clk_i, .srst_i, .fetch_kind_i, .queue_flush_cnt_i,
		.hist_flush_cnt_i, .debug_mode_i, .fetch_hold_o, .fss_wr_i,
		.fss_data_i, .instr_done_i, .fetch_show_select_o, .sync_set_i,
		.sync_clr_i, .trace_sync_o, .cyc_valid_i, .cyc_ready_o, .cyc_instr_i,
		.cyc_target_i, .cyc_cs_i, .cyc_resv_i, .cyc_write_i, .cyc_addr_i,
		.fetch_type_status_o, .history_flush_status_o, .bus_ack_i,
		.bus_valid_o, .cycle_type_code_o, .address_type_bit_o,
		.write_read_o, .bus_addr_o);

	pftr_trace_model i_pftr_trace_model (.clk_i(clk_i), .srst_i(srst_i),
		.stall_i(stall), .slow_i(slow), .vfls_i(history_flush_status_o),
		.bus_valid_i(bus_valid_o), .ct_i(cycle_type_code_o),
		.at_i(address_type_bit_o), .wr_i(write_read_o), .addr_i(bus_addr_o),
		.bus_ack_o(bus_ack_i), .cnt_o(m_cnt), .hist_o(m_hist), .ct_o(m_ct),
		.at_o(m_at), .wr_o(m_wr), .addr_o(m_addr));

	// ==========================================================
	// Shared tasks
	task finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	// One status clock: inputs at the falling edge, pins just after rising
	task st(input pftr_kind_t k, input logic [2:0] q, input logic [1:0] h,
		input logic d, input logic [2:0] ev, input logic [1:0] eh);
		@(negedge clk_i);
		fetch_kind_i = k;
		queue_flush_cnt_i = q;
		hist_flush_cnt_i = h;
		debug_mode_i = d;
		@(posedge clk_i);
		#1;
		chk("fetch_type_status", {29'h0, ev}, {29'h0, fetch_type_status_o});
		chk("history_flush", {30'h0, eh}, {30'h0, history_flush_status_o});
	endtask

	// Request held until an edge at which ready is high
	task send(input logic i, input pftr_target_t t, input logic [2:0] c,
		input logic r, input logic w, input logic [31:0] a);
		int k;
		@(negedge clk_i);
		cyc_valid_i = 1'b1;
		cyc_instr_i = i;
		cyc_target_i = t;
		cyc_cs_i = c;
		cyc_resv_i = r;
		cyc_write_i = w;
		cyc_addr_i = a;
		k = 0;
		while (cyc_ready_o !== 1'b1 && k < 60) begin
			@(negedge clk_i);
			k++;
		end
		@(negedge clk_i);
		cyc_valid_i = 1'b0;
	endtask

	// Sends a cycle and judges the next one the far side takes
	task cyc(input logic i, input pftr_target_t t, input logic [2:0] c,
		input logic r, input logic w, input logic [31:0] a,
		input logic [3:0] et, input logic ea, input logic ew);
		logic [15:0] n0;
		int k;
		n0 = m_cnt;
		send(i, t, c, r, w, a);
		k = 0;
		while (m_cnt !== n0 + 16'h1 && k < 60) begin
			@(negedge clk_i);
			k++;
		end
		chk("bus_cycles", {16'h0, n0 + 16'h1}, {16'h0, m_cnt});
		chk("cycle_type_code", {28'h0, et}, {28'h0, m_ct});
		chk("address_type_bit", {31'h0, ea}, {31'h0, m_at});
		chk("write_read", {31'h0, ew}, {31'h0, m_wr});
		chk("bus_addr", a, m_addr);
	endtask

	task pulse_done();
		@(negedge clk_i);
		instr_done_i = 1'b1;
		@(negedge clk_i);
		instr_done_i = 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task t_status();
		st(FK_DIRECT, 3'h0, 2'h1, 1'b0, 3'h6, 2'h1);
		st(FK_NONE, 3'h2, 2'h2, 1'b0, 3'h2, 2'h2);
		st(FK_SEQ, 3'h0, 2'h0, 1'b0, 3'h1, 2'h0);
		st(FK_EXC, 3'h0, 2'h0, 1'b0, 3'h4, 2'h0);
		st(FK_NONE, 3'h5, 2'h0, 1'b0, 3'h5, 2'h0);
		st(FK_INDIR, 3'h0, 2'h0, 1'b0, 3'h5, 2'h0);
		st(FK_NTAKEN, 3'h3, 2'h0, 1'b0, 3'h7, 2'h0);
		st(FK_NONE, 3'h4, 2'h0, 1'b0, 3'h4, 2'h0);
		st(FK_NTAKEN, 3'h0, 2'h0, 1'b0, 3'h2, 2'h0);
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h0, 2'h0);
		// The indirect branch left the next fetch tagged
		cyc(1, TG_EXT, 0, 0, 0, 32'h100, 4'h1, 1, 1);
		$display("test status done");
	endtask

	task t_cycles();
		slow = 1'b1;
		for (int j = 0; j < 8; j++) begin
			cyc(1, pftr_target_t'(j), 0, 0, 0, 32'h10 + j, ect[j], 1, 1);
		end
		for (int c = 1; c < 6; c++) begin
			cyc(1, TG_CCS, 3'(c), 0, 0, 32'h40 + c, 4'h8 + 4'(c), 1, 1);
		end
		cyc(0, TG_EXT, 0, 1, 0, 32'h50, 4'h1, 0, 0);
		cyc(0, TG_EXT, 0, 0, 1, 32'h54, 4'h0, 0, 1);
		slow = 1'b0;
		$display("test cycles done");
	endtask

	task t_debug();
		st(FK_SEQ, 3'h0, 2'h0, 1'b1, 3'h0, 2'h3);
		st(FK_SEQ, 3'h0, 2'h0, 1'b1, 3'h0, 2'h3);
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h5, 2'h0);
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h0, 2'h0);
		st(FK_NONE, 3'h0, 2'h0, 1'b1, 3'h0, 2'h3);
		@(negedge clk_i);
		sync_set_i = 1'b1;
		@(negedge clk_i);
		sync_set_i = 1'b0;
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h3, 2'h0);
		chk("trace_sync", 1, {31'h0, trace_sync_o});
		cyc(1, TG_LBUS, 0, 0, 0, 32'h60, 4'h5, 1, 0);
		$display("test debug done");
	endtask

	task t_sync();
		logic seen;
		seen = 1'b0;
		@(negedge clk_i);
		sync_clr_i = 1'b1;
		@(negedge clk_i);
		sync_clr_i = 1'b0;
		chk("fetch_hold", 1, {31'h0, fetch_hold_o});
		repeat (3) begin
			@(posedge clk_i);
			#1;
			if (fetch_type_status_o === 3'h3) seen = 1'b1;
		end
		chk("sync_report", 1, {31'h0, seen});
		chk("fetch_hold", 0, {31'h0, fetch_hold_o});
		chk("trace_sync", 0, {31'h0, trace_sync_o});
		cyc(1, TG_IBUS, 0, 0, 0, 32'h200, 4'h4, 1, 0);
		$display("test sync done");
	endtask

	task t_select();
		@(negedge clk_i);
		fss_wr_i = 1'b1;
		fss_data_i = 2'h3;
		// The boundary right after the move still runs under the old select
		@(negedge clk_i);
		fss_wr_i = 1'b0;
		instr_done_i = 1'b1;
		@(negedge clk_i);
		instr_done_i = 1'b0;
		chk("fetch_show_select", 0, {30'h0, fetch_show_select_o});
		pulse_done();
		chk("fetch_show_select", 3, {30'h0, fetch_show_select_o});
		// With sync clear even a tagged internal fetch stays off the bus
		st(FK_INDIR, 3'h0, 2'h0, 1'b0, 3'h5, 2'h0);
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h0, 2'h0);
		send(1, TG_IBUS, 0, 0, 0, 32'h300);
		cyc(0, TG_EXT, 0, 0, 1, 32'h304, 4'h0, 0, 1);
		@(negedge clk_i);
		sync_set_i = 1'b1;
		@(negedge clk_i);
		sync_set_i = 1'b0;
		repeat (4) @(negedge clk_i);
		cyc(1, TG_IBUS, 0, 0, 0, 32'h308, 4'h4, 1, 0);
		// Sync set: indirect targets show, direct targets do not
		st(FK_INDIR, 3'h0, 2'h0, 1'b0, 3'h5, 2'h0);
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h0, 2'h0);
		cyc(1, TG_IBUS, 0, 0, 0, 32'h30C, 4'h4, 1, 0);
		st(FK_DIRECT, 3'h0, 2'h0, 1'b0, 3'h6, 2'h0);
		st(FK_NONE, 3'h7, 2'h0, 1'b0, 3'h5, 2'h0);
		send(1, TG_IBUS, 0, 0, 0, 32'h310);
		cyc(0, TG_EXT, 0, 0, 1, 32'h314, 4'h0, 0, 1);
		$display("test select done");
	endtask

	// Write the show select and let two instruction boundaries pass
	task set_fss(input logic [1:0] v);
		@(negedge clk_i);
		fss_wr_i = 1'b1;
		fss_data_i = v;
		@(negedge clk_i);
		fss_wr_i = 1'b0;
		pulse_done();
		pulse_done();
		chk("fetch_show_select", {30'h0, v}, {30'h0, fetch_show_select_o});
	endtask

	// Select 01 adds direct targets, select 10 keeps only indirect ones
	task t_modes();
		set_fss(2'h1);
		send(1, TG_IBUS, 0, 0, 0, 32'h400);
		st(FK_DIRECT, 3'h0, 2'h0, 1'b0, 3'h6, 2'h0);
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h0, 2'h0);
		cyc(1, TG_IBUS, 0, 0, 0, 32'h404, 4'h4, 1, 1);
		set_fss(2'h2);
		st(FK_DIRECT, 3'h0, 2'h0, 1'b0, 3'h6, 2'h0);
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h0, 2'h0);
		send(1, TG_IBUS, 0, 0, 0, 32'h408);
		st(FK_INDIR, 3'h0, 2'h0, 1'b0, 3'h5, 2'h0);
		st(FK_NONE, 3'h0, 2'h0, 1'b0, 3'h0, 2'h0);
		cyc(1, TG_LBUS, 0, 0, 0, 32'h40C, 4'h5, 1, 0);
		$display("test modes done");
	endtask

	// Fill the queue against a stalled bus, then drain it in order
	task t_fill();
		int n;
		int k;
		logic r;
		logic [15:0] n0;
		n0 = m_cnt;
		stall = 1'b1;
		@(negedge clk_i);
		cyc_valid_i = 1'b1;
		cyc_instr_i = 1'b0;
		cyc_target_i = TG_EXT;
		cyc_resv_i = 1'b0;
		cyc_write_i = 1'b1;
		n = 0;
		cyc_addr_i = 32'h1000;
		repeat (30) begin
			r = cyc_ready_o;
			@(negedge clk_i);
			if (r === 1'b1) begin
				n++;
				cyc_addr_i = 32'h1000 + n;
			end
		end
		cyc_valid_i = 1'b0;
		chk("cyc_ready", 0, {31'h0, cyc_ready_o});
		chk("fill_in_range", 1, {31'h0, n >= 14 && n <= 16});
		stall = 1'b0;
		k = 0;
		while (m_cnt !== n0 + 16'(n) && k < 100) begin
			@(negedge clk_i);
			k++;
		end
		chk("drained", {16'h0, n0 + 16'(n)}, {16'h0, m_cnt});
		chk("last_addr", 32'h1000 + n - 1, m_addr);
		chk("bus_valid", 0, {31'h0, bus_valid_o});
		$display("test fill done");
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		#500000;
		n_errors++;
		finish_test();
	end

	initial begin
		srst_i = 1'b1;
		{debug_mode_i, fss_wr_i, instr_done_i, sync_set_i} = 4'h0;
		{sync_clr_i, cyc_valid_i, cyc_instr_i, cyc_resv_i} = 4'h0;
		{cyc_write_i, stall, slow} = 3'h0;
		fetch_kind_i = FK_NONE;
		cyc_target_i = TG_EXT;
		{queue_flush_cnt_i, cyc_cs_i} = 6'h0;
		{hist_flush_cnt_i, fss_data_i} = 4'h0;
		cyc_addr_i = 32'h0;
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		srst_i = 1'b0;
		@(negedge clk_i);
		chk("reset_vf", 0, {29'h0, fetch_type_status_o});
		chk("reset_vfls", 0, {30'h0, history_flush_status_o});
		chk("reset_select", 0, {30'h0, fetch_show_select_o});
		chk("reset_sync", 0, {31'h0, trace_sync_o});
		t_cycles();
		t_status();
		t_debug();
		t_sync();
		t_select();
		t_modes();
		t_fill();
		chk("history_total", 3, {16'h0, m_hist});
		finish_test();
	end
endmodule
